// >>> rtl/tfc_chan.sv
// One timer channel: capture, compare match and its event flag
`timescale 1ns/1ps
module tfc_chan (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the core
    tfc_chan_if.chan ch
);
    logic [1:0] sync_q; // Pin synchroniser, stage 0 first
    logic pin_prev_q; // Synchronised pin one cycle ago
    logic [15:0] value_q; // Channel value
    logic flag_q; // Channel event flag
    logic armed_q; // Flag was read while set
    logic capture; // Channel is in capture mode
    logic rise; // Rising edge seen
    logic fall; // Falling edge seen
    logic edge_hit; // Selected edge seen
    logic cap_evt; // Capture event
    logic match_evt; // Counter match event

    // Two stages before any logic sees the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 2'h0;
            pin_prev_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[0], ch.pin};
            pin_prev_q <= sync_q[1];
        end
    end

    // Centered counting turns every channel into a PWM channel
    assign capture = !ch.centered && (ch.mode == tfc_pkg::TFC_CAPTURE);
    assign rise = sync_q[1] && !pin_prev_q;
    assign fall = !sync_q[1] && pin_prev_q;

    always_comb begin
        case (ch.edge_sel)
            tfc_pkg::ELS_RISE: edge_hit = rise;
            tfc_pkg::ELS_FALL: edge_hit = fall;
            tfc_pkg::ELS_BOTH: edge_hit = rise || fall;
            default: edge_hit = 1'b0; // Off: capture disabled
        endcase
    end

    assign cap_evt = capture && edge_hit;
    // match on a fresh count; halted counter is silent
    assign match_evt = !capture && ch.cnt_new && (ch.cnt == value_q);

    // Value: capture beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= tfc_pkg::VALUE_RST;
        end else if (cap_evt) begin
            value_q <= ch.cnt;
        end else if (ch.val_wr) begin
            value_q <= ch.wdata;
        end
    end

    // two-step clear in every mode; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            {flag_q, armed_q} <= tfc_pkg::tfc_flag_next(flag_q, armed_q,
                cap_evt || match_evt, ch.flag_rd, ch.flag_wr0);
        end
    end

    assign ch.flag = flag_q;
    assign ch.value = value_q;

    a_cap_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_evt |=> flag_q && (value_q == $past(ch.cnt)))
        else $error("capture edge did not set flag and value");
    a_cap_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        (capture && ch.edge_sel == tfc_pkg::ELS_OFF && !flag_q) |=> !flag_q)
        else $error("flag set with capture edge off");
    a_match_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!capture && ch.cnt_new && ch.cnt == value_q) |=> flag_q && !armed_q)
        else $error("counter match did not set flag");
    a_ch_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(flag_q) |-> $past(armed_q) && $past(ch.flag_wr0))
        else $error("channel flag cleared without read then write");
endmodule // tfc_chan

// >>> rtl/tfc_chan_if.sv
// Link between the timer core and one channel
`timescale 1ns/1ps
interface tfc_chan_if;
    logic [15:0] cnt; // Counter value
    logic cnt_new; // Counter took a new value last edge
    logic centered; // Up/down counting active
    tfc_pkg::tfc_mode_t mode; // Channel mode field
    logic [1:0] edge_sel; // Capture edge selection
    logic pin; // Raw channel input pin
    logic val_wr; // Software writes the channel value
    logic [15:0] wdata; // Write data for the value
    logic flag_rd; // Flag read while set
    logic flag_wr0; // Zero written to the flag
    logic flag; // Channel event flag
    logic [15:0] value; // Channel value register
    modport core (output cnt, cnt_new, centered, mode, edge_sel, pin,
        val_wr, wdata, flag_rd, flag_wr0, input flag, value);
    modport chan (input cnt, cnt_new, centered, mode, edge_sel, pin,
        val_wr, wdata, flag_rd, flag_wr0, output flag, value);
endinterface

// >>> rtl/tfc_pkg.sv
// Shared constants, types and helpers for the timer flag logic
package tfc_pkg;
    // Channel count and widths, fixed
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned MODE_W = 2;
    localparam int unsigned ELS_W = 2;
    // Counter landmarks
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_MOD = 8'h08;
    localparam logic [7:0] OFS_CH_BASE = 8'h10;
    localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
    localparam logic [7:0] OFS_CH_VALUE = 8'h04;
    // Main control register fields
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_CENTERED_BIT = 1;
    localparam int unsigned CTRL_WIE_BIT = 2;
    localparam int unsigned CTRL_FLAG_BIT = 7;
    // Channel control register fields
    localparam int unsigned CH_MODE_LSB = 0;
    localparam int unsigned CH_ELS_LSB = 2;
    localparam int unsigned CH_IE_BIT = 4;
    localparam int unsigned CH_FLAG_BIT = 7;
    // Reset values
    localparam logic [15:0] MOD_RST = 16'h0000;
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Edge selection codes
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_BOTH = 2'h3;
    // Channel modes, in field order
    typedef enum logic [1:0] {
        TFC_CAPTURE, TFC_COMPARE, TFC_EPWM, TFC_EPWM_ALT
    } tfc_mode_t;
    // Counting direction
    typedef enum logic {TFC_UP, TFC_DOWN} tfc_dir_t;
    // Next {flag, armed}; a new event beats a clear and disarms
    function automatic logic [1:0] tfc_flag_next(input logic flag,
        input logic armed, input logic set_evt, input logic rd_set,
        input logic wr_zero);
        tfc_flag_next = {flag, armed};
        if (set_evt) begin
            tfc_flag_next = 2'h2;
        end else if (wr_zero && armed) begin
            tfc_flag_next = 2'h0;
        end else if (rd_set) begin
            tfc_flag_next = 2'h3;
        end
    endfunction
endpackage

// >>> rtl/tfc_top.sv
// Timer counter with wrap and channel event flags behind APB
//
// Summary of operation
// - Free-running counter runs zero to maximum, wraps
// - Wrap flag set at maximum to zero
// - Wrap flag set at modulus to zero
// - Up/down: wrap flag at reversal from modulus
// - Reversal ends period; zero is mid-period
// - Capture edge: rising, falling, both or off
// - Selected capture edge sets channel flag
// - Compare: counter equal value sets flag
// - Edge PWM: counter match sets flag
// - Centered PWM: both matches set flag
// - Two-step flag clear in every channel mode
// - Clear needs read while set, then zero
// - Event between steps restarts clear sequence
// - Enabled flag holds level interrupt request
`timescale 1ns/1ps
module tfc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel input pins
    input wire logic [1:0] chan_in,
    // Level interrupt request
    output logic timer_irq
);
    localparam int unsigned N = tfc_pkg::NUM_CH;

    logic run_q; // Counter runs
    logic centered_pwm_select_q; // Up/down counting, channels as PWM
    logic wie_q; // Wrap interrupt enable
    logic [15:0] mod_q; // Modulus, zero means free running
    logic [15:0] cnt_q; // Main counter
    logic [15:0] cnt_d;
    tfc_pkg::tfc_dir_t dir_q; // Counting direction
    tfc_pkg::tfc_dir_t dir_d;
    logic cnt_new_q; // Counter took a new value last edge
    logic wrap_evt; // Counter wraps at the maximum or modulus, or reverses at the modulus, this edge
    logic wflag_q; // Counter wrap flag
    logic warmed_q; // Wrap flag read while set
    tfc_pkg::tfc_mode_t ch_mode_q [N]; // Channel modes
    logic [1:0] ch_els_q [N]; // Channel edge selects
    logic [N-1:0] ch_ie_q; // Channel interrupt enables
    logic [N-1:0] ch_flag; // Channel flags from channels
    logic [15:0] ch_value [N]; // Channel values from channels
    logic [31:0] prdata_q; // Read data, loaded in setup
    logic [31:0] rdata_d;
    logic pslverr_q; // Unmapped address answer
    logic setup; // APB setup phase
    logic wr; // Write access phase
    logic rd; // Read access phase
    logic hit_ctrl; // Address decode results
    logic hit_count;
    logic hit_mod;
    logic [N-1:0] hit_chc;
    logic [N-1:0] hit_chv;
    logic hit_any;
    logic wrap_rd; // Wrap flag read while set
    logic wrap_wr0; // Zero written to the wrap flag

    // Byte offset of a channel's control register
    function automatic logic [7:0] ch_ofs(input int unsigned idx);
        ch_ofs = tfc_pkg::OFS_CH_BASE + 8'(idx) * tfc_pkg::OFS_CH_STRIDE;
    endfunction

    // APB phases; every access completes in one access cycle
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // Address decode; unaligned addresses miss and give an error
    always_comb begin
        hit_ctrl = 1'b0;
        hit_count = 1'b0;
        hit_mod = 1'b0;
        hit_chc = '0;
        hit_chv = '0;
        if (paddr == tfc_pkg::OFS_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == tfc_pkg::OFS_COUNT) begin
            hit_count = 1'b1;
        end else if (paddr == tfc_pkg::OFS_MOD) begin
            hit_mod = 1'b1;
        end
        for (int i = 0; i < N; i++) begin
            if (paddr == ch_ofs(i)) begin
                hit_chc[i] = 1'b1;
            end else if (paddr == ch_ofs(i) + tfc_pkg::OFS_CH_VALUE) begin
                hit_chv[i] = 1'b1;
            end
        end
        hit_any = hit_ctrl || hit_count || hit_mod || (|hit_chc) ||
            (|hit_chv);
    end

    // Read mux; reserved bits read zero
    always_comb begin
        rdata_d = tfc_pkg::RDATA_RST;
        if (hit_ctrl) begin
            rdata_d[tfc_pkg::CTRL_RUN_BIT] = run_q;
            rdata_d[tfc_pkg::CTRL_CENTERED_BIT] = centered_pwm_select_q;
            rdata_d[tfc_pkg::CTRL_WIE_BIT] = wie_q;
            rdata_d[tfc_pkg::CTRL_FLAG_BIT] = wflag_q;
        end else if (hit_count) begin
            rdata_d[tfc_pkg::CNT_W-1:0] = cnt_q;
        end else if (hit_mod) begin
            rdata_d[tfc_pkg::CNT_W-1:0] = mod_q;
        end
        for (int i = 0; i < N; i++) begin
            if (hit_chc[i]) begin
                rdata_d[tfc_pkg::CH_MODE_LSB +: tfc_pkg::MODE_W] =
                    ch_mode_q[i];
                rdata_d[tfc_pkg::CH_ELS_LSB +: tfc_pkg::ELS_W] = ch_els_q[i];
                rdata_d[tfc_pkg::CH_IE_BIT] = ch_ie_q[i];
                rdata_d[tfc_pkg::CH_FLAG_BIT] = ch_flag[i];
            end else if (hit_chv[i]) begin
                rdata_d[tfc_pkg::CNT_W-1:0] = ch_value[i];
            end
        end
    end

    // Read data and error are caught in setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= tfc_pkg::RDATA_RST;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? tfc_pkg::RDATA_RST : rdata_d;
            pslverr_q <= !hit_any;
        end
    end

    // Main control and modulus registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            centered_pwm_select_q <= 1'b0;
            wie_q <= 1'b0;
            mod_q <= tfc_pkg::MOD_RST;
        end else if (wr && hit_ctrl) begin
            run_q <= pwdata[tfc_pkg::CTRL_RUN_BIT];
            centered_pwm_select_q <= pwdata[tfc_pkg::CTRL_CENTERED_BIT];
            wie_q <= pwdata[tfc_pkg::CTRL_WIE_BIT];
        end else if (wr && hit_mod) begin
            mod_q <= pwdata[tfc_pkg::CNT_W-1:0];
        end
    end

    // Channel control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_ie_q <= '0;
            for (int i = 0; i < N; i++) begin
                ch_mode_q[i] <= tfc_pkg::TFC_CAPTURE;
                ch_els_q[i] <= tfc_pkg::ELS_OFF;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (wr && hit_chc[i]) begin
                    ch_mode_q[i] <= tfc_pkg::tfc_mode_t'(
                        pwdata[tfc_pkg::CH_MODE_LSB +: tfc_pkg::MODE_W]);
                    ch_els_q[i] <= pwdata[tfc_pkg::CH_ELS_LSB +:
                        tfc_pkg::ELS_W];
                    ch_ie_q[i] <= pwdata[tfc_pkg::CH_IE_BIT];
                end
            end
        end
    end

    // Counter next state; a zero modulus with centered counting is
    // not supported and simply runs down through the top value
    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        wrap_evt = 1'b0;
        if (run_q) begin
            case (dir_q)
                tfc_pkg::TFC_UP: begin
                    if (centered_pwm_select_q && cnt_q == mod_q) begin
                        dir_d = tfc_pkg::TFC_DOWN;
                        cnt_d = cnt_q - tfc_pkg::CNT_ONE;
                        wrap_evt = 1'b1;
                    end else if (!centered_pwm_select_q &&
                        (cnt_q == tfc_pkg::CNT_MAX ||
                        (mod_q != tfc_pkg::CNT_ZERO && cnt_q == mod_q))) begin
                        // wrap from maximum or modulus to zero
                        cnt_d = tfc_pkg::CNT_ZERO;
                        wrap_evt = 1'b1;
                    end else begin
                        cnt_d = cnt_q + tfc_pkg::CNT_ONE;
                    end
                end
                tfc_pkg::TFC_DOWN: begin
                    // zero is the middle of a centered period
                    if (!centered_pwm_select_q ||
                        cnt_q == tfc_pkg::CNT_ZERO) begin
                        dir_d = tfc_pkg::TFC_UP;
                        cnt_d = cnt_q + tfc_pkg::CNT_ONE;
                    end else begin
                        cnt_d = cnt_q - tfc_pkg::CNT_ONE;
                    end
                end
                default: dir_d = tfc_pkg::TFC_UP;
            endcase
        end
    end

    // Counter; any write to it restarts from zero, counting up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= tfc_pkg::CNT_ZERO;
            dir_q <= tfc_pkg::TFC_UP;
            cnt_new_q <= 1'b0;
        end else if (wr && hit_count) begin
            cnt_q <= tfc_pkg::CNT_ZERO;
            dir_q <= tfc_pkg::TFC_UP;
            cnt_new_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            cnt_new_q <= run_q;
        end
    end

    // read while set arms; a later zero write clears
    assign wrap_rd = rd && hit_ctrl && prdata_q[tfc_pkg::CTRL_FLAG_BIT];
    assign wrap_wr0 = wr && hit_ctrl && !pwdata[tfc_pkg::CTRL_FLAG_BIT];

    // a wrap between the steps restarts the sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wflag_q <= 1'b0;
            warmed_q <= 1'b0;
        end else begin
            {wflag_q, warmed_q} <= tfc_pkg::tfc_flag_next(wflag_q,
                warmed_q, wrap_evt, wrap_rd, wrap_wr0);
        end
    end

    // One channel block per channel, joined by an interface
    for (genvar g = 0; g < N; g++) begin : g_ch
        tfc_chan_if ch_if ();
        assign ch_if.cnt = cnt_q;
        assign ch_if.cnt_new = cnt_new_q;
        assign ch_if.centered = centered_pwm_select_q;
        assign ch_if.mode = ch_mode_q[g];
        assign ch_if.edge_sel = ch_els_q[g];
        assign ch_if.pin = chan_in[g];
        assign ch_if.val_wr = wr && hit_chv[g];
        assign ch_if.wdata = pwdata[tfc_pkg::CNT_W-1:0];
        // both clear steps reach only the addressed channel
        assign ch_if.flag_rd = rd && hit_chc[g] &&
            prdata_q[tfc_pkg::CH_FLAG_BIT];
        assign ch_if.flag_wr0 = wr && hit_chc[g] &&
            !pwdata[tfc_pkg::CH_FLAG_BIT];
        assign ch_flag[g] = ch_if.flag;
        assign ch_value[g] = ch_if.value;
        tfc_chan u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .ch(ch_if)
        );
    end

    // level request while an enabled flag is set
    assign timer_irq = (wflag_q && wie_q) || (|(ch_flag & ch_ie_q));

    a_free_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run_q && !centered_pwm_select_q && dir_q == tfc_pkg::TFC_UP &&
         cnt_q == tfc_pkg::CNT_MAX && !(wr && hit_count))
        |=> cnt_q == tfc_pkg::CNT_ZERO && wflag_q)
        else $error("no wrap from maximum to zero");
    a_free_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run_q && !centered_pwm_select_q && mod_q == tfc_pkg::CNT_ZERO &&
         cnt_q != tfc_pkg::CNT_MAX && !(wr && hit_count))
        |=> cnt_q == $past(cnt_q) + tfc_pkg::CNT_ONE)
        else $error("free counter did not step by one");
    a_mod_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run_q && !centered_pwm_select_q && mod_q != tfc_pkg::CNT_ZERO &&
         cnt_q == mod_q && !(wr && hit_count))
        |=> cnt_q == tfc_pkg::CNT_ZERO && wflag_q)
        else $error("no wrap from modulus to zero");
    a_updown_turn: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run_q && centered_pwm_select_q && dir_q == tfc_pkg::TFC_UP &&
         cnt_q == mod_q &&
         mod_q != tfc_pkg::CNT_ZERO && !(wr && hit_count))
        |=> dir_q == tfc_pkg::TFC_DOWN && wflag_q &&
            cnt_q == $past(mod_q) - tfc_pkg::CNT_ONE)
        else $error("no wrap at up/down reversal");
    a_center_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (run_q && centered_pwm_select_q && dir_q == tfc_pkg::TFC_DOWN &&
         cnt_q == tfc_pkg::CNT_ZERO) |-> !wrap_evt ##1
         (dir_q == tfc_pkg::TFC_UP || (wr && $past(hit_count))))
        else $error("zero count mishandled in centered mode");
    a_clear_order: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(wflag_q) |-> $past(warmed_q) && $past(wrap_wr0))
        else $error("wrap flag cleared without read then write");
    a_set_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        wrap_evt |=> wflag_q && !warmed_q)
        else $error("wrap event lost or clear not restarted");
    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        timer_irq == ((wflag_q && wie_q) || (|(ch_flag & ch_ie_q))))
        else $error("interrupt level does not follow flags");
endmodule // tfc_top

// >>> verif/tfc_top_tb.sv
// Self-checking bench for the timer wrap and channel event flags
`timescale 1ns/1ps
module tfc_top_tb;
    // Clock, reset and APB drive
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    // Design answers
    logic [31:0] prdata;
    logic pready, pslverr, timer_irq;
    // Channel pins driven by the bench
    logic [1:0] chan_in;
    // Score counters
    int n_errors = 0;
    int n_tests = 0;
    // Last read word
    logic [31:0] r;

    tfc_top tfc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_in(chan_in), .timer_irq(timer_irq));

    // Free-running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Verdict and end of run
    task automatic results();
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Four-state compare, so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            results();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Idle cycles
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Register reset values and an unmapped address
    task automatic t_reset();
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0000, "ctrl reset");
        chk({31'h0, timer_irq}, 32'h0000_0000, "irq reset");
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0, pslverr}, 32'h0000_0001, "unmapped err");
        chk(r, 32'h0000_0000, "unmapped data");
    endtask

    // Modulus wrap, then the two-step clear and the level request
    task automatic t_modwrap();
        logic [31:0] top;
        top = 32'h0000_0000;
        apb(1'b1, tfc_pkg::OFS_MOD, 32'h0000_0008);
        apb(1'b1, tfc_pkg::OFS_COUNT, 32'h0000_0000);
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0001);
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0001, "no wrap yet");
        // Several periods of polling; the count never passes the modulus
        repeat (12) begin
            apb(1'b0, tfc_pkg::OFS_COUNT, 32'h0000_0000);
            if (r > top) top = r;
            // Four-cycle spacing walks every phase of the nine-count period
            idle(1);
        end
        chk(top, 32'h0000_0008, "count peak");
        // Zero without an armed read must not clear
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0080, "unarmed clear");
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0084);
        // Enable lands at the access edge; look once it has settled
        idle(1);
        chk({31'h0, timer_irq}, 32'h0000_0001, "wrap irq");
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0004);
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0004, "armed clear");
        idle(1);
        chk({31'h0, timer_irq}, 32'h0000_0000, "irq drops");
    endtask

    // Free-running count to the maximum and back to zero
    task automatic t_freewrap();
        apb(1'b1, tfc_pkg::OFS_MOD, 32'h0000_0000);
        apb(1'b1, tfc_pkg::OFS_COUNT, 32'h0000_0000);
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0001);
        idle(60000);
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0001, "free no wrap");
        apb(1'b0, tfc_pkg::OFS_COUNT, 32'h0000_0000);
        chk({31'h0, r > 32'd60000}, 32'h0000_0001, "count climbs");
        idle(6000);
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0081, "free wrap");
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0000);
    endtask

    // Every edge selection code against both pin edges on channel one
    task automatic t_capture();
        logic [1:0] e;
        logic exp;
        for (int i = 0; i < 8; i++) begin
            e = 2'(i / 2);
            exp = (e == tfc_pkg::ELS_BOTH) || (i % 2 == 0 ?
                e == tfc_pkg::ELS_RISE : e == tfc_pkg::ELS_FALL);
            apb(1'b0, 8'h18, 32'h0000_0000);
            apb(1'b1, 8'h18, {28'h0, e, 2'h0});
            chan_in[1] <= (i % 2 == 0);
            idle(8);
            apb(1'b0, 8'h18, 32'h0000_0000);
            chk({31'h0, r[7]}, {31'h0, exp}, "capture edge");
        end
    endtask

    // A new event between read and write keeps the flag
    task automatic t_restart();
        apb(1'b1, 8'h10, 32'h0000_0094);
        chan_in[0] <= 1'b1;
        idle(8);
        chk({31'h0, timer_irq}, 32'h0000_0001, "chan irq");
        apb(1'b0, 8'h10, 32'h0000_0000);
        chan_in[0] <= 1'b0;
        idle(4);
        chan_in[0] <= 1'b1;
        idle(8);
        apb(1'b1, 8'h10, 32'h0000_0014);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(r, 32'h0000_0094, "restart keeps");
        apb(1'b1, 8'h10, 32'h0000_0014);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(r, 32'h0000_0014, "second clear");
        chk({31'h0, timer_irq}, 32'h0000_0000, "irq off");
    endtask

    // Compare and edge PWM: match sets the flag, no match never does
    task automatic t_compare();
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0001);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, 8'h14, 32'h0000_0020);
            apb(1'b0, 8'h10, 32'h0000_0000);
            apb(1'b1, 8'h10, 32'(m));
            idle(30);
            apb(1'b0, 8'h10, 32'h0000_0000);
            chk(r, 32'(m), "no match");
            apb(1'b1, 8'h14, 32'h0000_0005);
            // Restart the count so it passes the new value soon
            apb(1'b1, tfc_pkg::OFS_COUNT, 32'h0000_0000);
            idle(30);
            apb(1'b0, 8'h10, 32'h0000_0000);
            chk(r, 32'(m) | 32'h0000_0080, "match");
        end
    endtask

    // Up/down counting: reversal at the modulus, a match sets the flag
    task automatic t_centered();
        logic [31:0] prev;
        logic down;
        down = 1'b0;
        prev = 32'h0000_0000;
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, 8'h14, 32'h0000_0020);
        apb(1'b1, tfc_pkg::OFS_MOD, 32'h0000_0006);
        apb(1'b1, tfc_pkg::OFS_COUNT, 32'h0000_0000);
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, tfc_pkg::OFS_CTRL, 32'h0000_0003);
        repeat (10) begin
            apb(1'b0, tfc_pkg::OFS_COUNT, 32'h0000_0000);
            chk({31'h0, r <= 32'd6}, 32'h0000_0001, "below mod");
            if (r < prev) down = 1'b1;
            prev = r;
        end
        chk({31'h0, down}, 32'h0000_0001, "counts down");
        apb(1'b0, tfc_pkg::OFS_CTRL, 32'h0000_0000);
        chk(r, 32'h0000_0083, "reversal wrap");
        apb(1'b0, 8'h10, 32'h0000_0000);
        apb(1'b1, 8'h10, 32'h0000_0001);
        apb(1'b1, 8'h14, 32'h0000_0003);
        idle(20);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(r, 32'h0000_0081, "centered match");
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        chan_in = 2'h0;
        idle(2);
        presetn <= 1'b1;
        t_reset();
        t_modwrap();
        t_freewrap();
        t_capture();
        t_restart();
        t_compare();
        t_centered();
        results();
    end
endmodule // tfc_top_tb
